// [hdl/bld_pkg.sv]
/*
 * Constants for the bridge legacy decode and system-error forwarding block:
 * register map, field positions, reset values, legacy address ranges.
 * Assumes a 32-bit APB register bus with aligned word registers.
 */
package bld_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h00;
    localparam logic [7:0] OFS_COMMAND     = 8'h04;
    localparam logic [7:0] OFS_IO_BASE     = 8'h08;
    localparam logic [7:0] OFS_IO_LIMIT    = 8'h0C;
    localparam logic [7:0] OFS_MEM_BASE    = 8'h10;
    localparam logic [7:0] OFS_MEM_LIMIT   = 8'h14;
    localparam logic [7:0] OFS_INT_STATUS  = 8'h18;
    localparam logic [7:0] OFS_INT_MASK    = 8'h1C;
    localparam logic [7:0] OFS_FWD_STATUS  = 8'h20;

    // Bridge control field positions
    localparam int BC_SYS_ERR_FWD_EN   = 1;
    localparam int BC_LEGACY_IO_ALIAS  = 2;
    localparam int BC_LEGACY_DISP_EN   = 3;
    localparam int BC_LEGACY_FULL_DEC  = 4;
    localparam logic [15:0] BC_RW_MASK = 16'h001E;
    localparam logic [15:0] BC_RESET   = 16'h0000;

    // Command field positions
    localparam int CMD_IO_SPACE_EN     = 0;
    localparam int CMD_MEM_SPACE_EN    = 1;
    localparam int CMD_SYS_ERR_REP_EN  = 8;
    localparam logic [15:0] CMD_RW_MASK = 16'h0103;
    localparam logic [15:0] CMD_RESET   = 16'h0000;

    // Window reset values (empty windows: base above limit)
    localparam logic [31:0] WIN_BASE_RESET  = 32'hFFFFFFFF;
    localparam logic [31:0] WIN_LIMIT_RESET = 32'h00000000;

    // Interrupt events
    localparam int NUM_EVT       = 3;
    localparam int EVT_SYS_ERR   = 0;
    localparam int EVT_DN_BLOCK  = 1;
    localparam int EVT_UP_REFUSE = 2;
    localparam logic [NUM_EVT-1:0] INT_RESET = 3'h0;

    // Legacy display ranges
    localparam logic [31:0] LEG_MEM_LO  = 32'h000A0000;
    localparam logic [31:0] LEG_MEM_HI  = 32'h000BFFFF;
    localparam logic [9:0]  LEG_IO_A_LO = 10'h3B0;
    localparam logic [9:0]  LEG_IO_A_HI = 10'h3BB;
    localparam logic [9:0]  LEG_IO_B_LO = 10'h3C0;
    localparam logic [9:0]  LEG_IO_B_HI = 10'h3DF;

endpackage

// [hdl/bld_dec_if.sv]
/*
 * Carrier between the top block and one address decoder instance.
 * Assumes the decoder is purely combinational.
 */
`timescale 1ns/1ps
interface bld_dec_if;
    logic [31:0] addr;        // Address under decode
    logic        is_io;       // 1 = I/O access, 0 = memory
    logic        disp_en;     // Legacy display forwarding on
    logic        full_dec;    // Compare alias bits too
    logic [31:0] io_base;     // I/O window base
    logic [31:0] io_limit;    // I/O window limit
    logic [31:0] mem_base;    // Memory window base
    logic [31:0] mem_limit;   // Memory window limit
    logic        legacy_hit;  // Legacy display address matched
    logic        in_win;      // Inside programmed window
    logic        alias_top;   // I/O, low 64 KB, top 768 bytes of 1 KB

    modport user (output addr, is_io, disp_en, full_dec, io_base, io_limit,
                  mem_base, mem_limit, input legacy_hit, in_win, alias_top);
    modport dec  (input addr, is_io, disp_en, full_dec, io_base, io_limit,
                  mem_base, mem_limit, output legacy_hit, in_win, alias_top);
endinterface

// [hdl/bld_addr_decode.sv]
/*
 * Combinational address decoder: legacy display ranges, window hit and
 * alias position. Assumes the caller registers the results.
 */
`timescale 1ns/1ps
module bld_addr_decode
    import bld_pkg::*;
(
    bld_dec_if.dec d
);
    wire        low64k;    // Upper address bits all zero
    wire [9:0]  lo10;      // Low ten address bits
    wire        io_rng;    // Low bits in a legacy display range
    wire        alias_ok;  // Alias bits accepted
    wire        io_leg;    // Legacy display I/O hit
    wire        mem_leg;   // Legacy display memory hit
    wire        io_win;    // Inside I/O window
    wire        mem_win;   // Inside memory window

    assign low64k  = (d.addr[31:16] == 16'h0000);
    assign lo10    = d.addr[9:0];
    assign io_rng  = ((lo10 >= LEG_IO_A_LO) && (lo10 <= LEG_IO_A_HI)) ||
                     ((lo10 >= LEG_IO_B_LO) && (lo10 <= LEG_IO_B_HI));
    // Aliases ignored unless full decode asked for
    assign alias_ok = !d.full_dec || (d.addr[15:10] == 6'h00);
    assign io_leg   = d.is_io && low64k && io_rng && alias_ok;
    assign mem_leg  = !d.is_io && (d.addr >= LEG_MEM_LO) &&
                      (d.addr <= LEG_MEM_HI);
    // Display hit ignores windows and alias control
    assign d.legacy_hit = d.disp_en && (io_leg || mem_leg);

    assign io_win  = (d.addr >= d.io_base) && (d.addr <= d.io_limit);
    assign mem_win = (d.addr >= d.mem_base) && (d.addr <= d.mem_limit);
    assign d.in_win = d.is_io ? io_win : mem_win;

    // Top 768 bytes of each 1 KB block: offset bits 9:8 nonzero
    assign d.alias_top = d.is_io && io_win && low64k &&
                         (d.addr[9:8] != 2'b00);
endmodule

// [hdl/bld_top.sv]
/*
 * Legacy display forwarding, I/O alias filtering and system-error
 * forwarding for a bridge, with an APB register slave and interrupt.
 * Assumes decode requests arrive synchronous to pclk, one per cycle each.
 */
// The placing of the registers and register access over APB were left to the implementer.
//
// Summary of operation
// - Display memory A0000-BFFFF forwarded downstream when enabled
// - Display I/O 3B0-3BB, 3C0-3DF forwarded downstream
// - Display I/O needs high bits zero, aliases ignored
// - Display addresses refused upstream while enabled
// - Display forwarding ignores alias bit and windows
// - Display forwarding needs I/O or memory space enable
// - Alias control covers windowed I/O below 64 KB
// - Alias set blocks downstream top 768 bytes
// - Alias set forwards upstream top 768 bytes
// - Alias clear forwards whole I/O window downstream
// - Error forwarded needs secondary error, both enables
// - Error forwarding bit resets to zero
// - Control bits 4, 3, 2, 1 are read/write
// - Full decode bit also compares bits 15:10
//
`timescale 1ns/1ps
module bld_top
    import bld_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Downstream request from primary side
    input  wire logic        dn_req_valid,
    input  wire logic        dn_req_io,
    input  wire logic [31:0] dn_req_addr,
    output logic             dn_done,
    output logic             dn_fwd,
    // Upstream request from secondary side
    input  wire logic        up_req_valid,
    input  wire logic        up_req_io,
    input  wire logic [31:0] up_req_addr,
    output logic             up_done,
    output logic             up_fwd,
    // System error
    input  wire logic        sec_sys_err_n,
    output logic             pri_sys_err,
    // Interrupt
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    ////////////////////////////////////////////////////////////////////////
    logic [15:0]        bridge_control;  // Bridge control
    logic [15:0]        command;         // Command enables
    logic [31:0]        io_base;         // I/O window base
    logic [31:0]        io_limit;        // I/O window limit
    logic [31:0]        mem_base;        // Memory window base
    logic [31:0]        mem_limit;       // Memory window limit
    logic [NUM_EVT-1:0] int_status;      // Sticky events
    logic [NUM_EVT-1:0] int_mask;        // Interrupt enables
    logic               sys_err_prev;    // Previous secondary error level

    ////////////////////////////////////////////////////////////////////////
    // Control bit decode
    ////////////////////////////////////////////////////////////////////////
    wire disp_en      = bridge_control[BC_LEGACY_DISP_EN];
    wire alias_en     = bridge_control[BC_LEGACY_IO_ALIAS];
    wire full_dec     = bridge_control[BC_LEGACY_FULL_DEC];
    wire serr_fwd_en  = bridge_control[BC_SYS_ERR_FWD_EN];
    wire cmd_io_en    = command[CMD_IO_SPACE_EN];
    wire cmd_mem_en   = command[CMD_MEM_SPACE_EN];
    wire cmd_sys_err_report_en = command[CMD_SYS_ERR_REP_EN];

    ////////////////////////////////////////////////////////////////////////
    // Address decoders, one per direction
    ////////////////////////////////////////////////////////////////////////
    bld_dec_if dn_if ();
    bld_dec_if up_if ();

    // Downstream decoder inputs
    assign dn_if.addr      = dn_req_addr;
    assign dn_if.is_io     = dn_req_io;
    assign dn_if.disp_en   = disp_en;
    assign dn_if.full_dec  = full_dec;
    assign dn_if.io_base   = io_base;
    assign dn_if.io_limit  = io_limit;
    assign dn_if.mem_base  = mem_base;
    assign dn_if.mem_limit = mem_limit;

    // Upstream decoder inputs
    assign up_if.addr      = up_req_addr;
    assign up_if.is_io     = up_req_io;
    assign up_if.disp_en   = disp_en;
    assign up_if.full_dec  = full_dec;
    assign up_if.io_base   = io_base;
    assign up_if.io_limit  = io_limit;
    assign up_if.mem_base  = mem_base;
    assign up_if.mem_limit = mem_limit;

    bld_addr_decode u_dn_dec (
        .d (dn_if.dec)
    );

    bld_addr_decode u_up_dec (
        .d (up_if.dec)
    );

    ////////////////////////////////////////////////////////////////////////
    // Forwarding decisions
    ////////////////////////////////////////////////////////////////////////
    wire dn_space_en;   // Space enable for the downstream access
    wire dn_alias_blk;  // Alias filter blocks downstream access
    wire dn_leg_fwd;    // Legacy display claim
    wire dn_win_fwd;    // Window claim
    wire next_dn_fwd;   // Downstream decision
    wire up_alias_fwd;  // Alias filter forces upstream
    wire up_leg_ref;    // Legacy display refusal upstream
    wire next_up_fwd;   // Upstream decision

    // Space enable from the command register
    assign dn_space_en  = dn_req_io ? cmd_io_en : cmd_mem_en;
    // Legacy display claim wins over windows and alias control
    assign dn_leg_fwd   = dn_if.legacy_hit && dn_space_en;
    // Alias filter only while alias control is set
    assign dn_alias_blk = alias_en && dn_if.alias_top;
    // Window claim; the only path when display forwarding is off
    assign dn_win_fwd   = dn_if.in_win && dn_space_en &&
                          !dn_alias_blk;
    assign next_dn_fwd  = dn_leg_fwd || dn_win_fwd;

    // Upstream: outside the window, or alias-top I/O when filtering
    assign up_alias_fwd = alias_en && up_if.alias_top;
    assign up_leg_ref   = up_if.legacy_hit;
    assign next_up_fwd  = !up_leg_ref &&
                          (!up_if.in_win || up_alias_fwd);

    // System error: new assertion while both enables set
    wire sys_err_now    = !sec_sys_err_n;
    wire next_sys_err   = sys_err_now && !sys_err_prev &&
                          serr_fwd_en && cmd_sys_err_report_en;

    ////////////////////////////////////////////////////////////////////////
    // Decision registers, sampled in the request cycle
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dn_done <= 1'b0;
            dn_fwd  <= 1'b0;
            up_done <= 1'b0;
            up_fwd  <= 1'b0;
        end else begin
            // Control bits in force this cycle decide the outcome
            dn_done <= dn_req_valid;
            dn_fwd  <= dn_req_valid && next_dn_fwd;
            up_done <= up_req_valid;
            up_fwd  <= up_req_valid && next_up_fwd;
        end
    end

    // System error edge detect and forward pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_err_prev <= 1'b0;
            pri_sys_err  <= 1'b0;
        end else begin
            sys_err_prev <= sys_err_now;
            pri_sys_err  <= next_sys_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode
    ////////////////////////////////////////////////////////////////////////
    wire acc_phase = psel && penable;             // Access phase
    wire wr_take   = acc_phase && pwrite && pready; // Write completes
    wire rd_load   = acc_phase && !pready;        // Load read data
    wire sel_bc    = (paddr == OFS_BRIDGE_CTRL);
    wire sel_cmd   = (paddr == OFS_COMMAND);
    wire sel_iob   = (paddr == OFS_IO_BASE);
    wire sel_iol   = (paddr == OFS_IO_LIMIT);
    wire sel_mb    = (paddr == OFS_MEM_BASE);
    wire sel_ml    = (paddr == OFS_MEM_LIMIT);
    wire sel_ist   = (paddr == OFS_INT_STATUS);
    wire sel_imk   = (paddr == OFS_INT_MASK);
    wire sel_fst   = (paddr == OFS_FWD_STATUS);
    wire mapped    = sel_bc || sel_cmd || sel_iob || sel_iol || sel_mb ||
                     sel_ml || sel_ist || sel_imk || sel_fst;

    // Read data mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (1'b1)
            sel_bc:  rd_mux = {16'h0000, bridge_control};
            sel_cmd: rd_mux = {16'h0000, command};
            sel_iob: rd_mux = io_base;
            sel_iol: rd_mux = io_limit;
            sel_mb:  rd_mux = mem_base;
            sel_ml:  rd_mux = mem_limit;
            sel_ist: rd_mux = {{(32-NUM_EVT){1'b0}}, int_status};
            sel_imk: rd_mux = {{(32-NUM_EVT){1'b0}}, int_mask};
            sel_fst: rd_mux = {28'h0000000, up_fwd, up_done, dn_fwd, dn_done};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // One wait state, then completion with data or error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= rd_load;
            pslverr <= rd_load && !mapped;
            if (rd_load && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and window registers
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bridge_control <= BC_RESET;
            command        <= CMD_RESET;
        end else if (wr_take) begin
            if (sel_bc) begin
                bridge_control <= pwdata[15:0] & BC_RW_MASK;
            end
            if (sel_cmd) begin
                command <= pwdata[15:0] & CMD_RW_MASK;
            end
        end
    end

    // Window registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_base   <= WIN_BASE_RESET;
            io_limit  <= WIN_LIMIT_RESET;
            mem_base  <= WIN_BASE_RESET;
            mem_limit <= WIN_LIMIT_RESET;
        end else if (wr_take) begin
            if (sel_iob) begin
                io_base <= pwdata;
            end
            if (sel_iol) begin
                io_limit <= pwdata;
            end
            if (sel_mb) begin
                mem_base <= pwdata;
            end
            if (sel_ml) begin
                mem_limit <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask
    ////////////////////////////////////////////////////////////////////////
    wire [NUM_EVT-1:0] evt;        // Event pulses
    wire [NUM_EVT-1:0] clr;        // Write-one-to-clear
    wire [NUM_EVT-1:0] next_stat;  // Next status

    assign evt[EVT_SYS_ERR]   = next_sys_err;
    assign evt[EVT_DN_BLOCK]  = dn_req_valid && !dn_leg_fwd &&
                                dn_if.in_win && dn_alias_blk;
    assign evt[EVT_UP_REFUSE] = up_req_valid && up_leg_ref;
    assign clr = (wr_take && sel_ist) ? pwdata[NUM_EVT-1:0] : {NUM_EVT{1'b0}};

    // Set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi = gi + 1) begin : g_stat
            assign next_stat[gi] = evt[gi] || (int_status[gi] && !clr[gi]);
        end
    endgenerate

    // Status, mask and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= INT_RESET;
            int_mask   <= INT_RESET;
            irq        <= 1'b0;
        end else begin
            int_status <= next_stat;
            if (wr_take && sel_imk) begin
                int_mask <= pwdata[NUM_EVT-1:0];
            end
            irq <= |(next_stat & int_mask);
        end
    end

endmodule

// [testbench/bld_top_assertions.sv]
/* Port checker for bld_top: decode answers, APB handshake, error pulse.
   Assumes one pclk domain and presetn asynchronous, active low. */
`timescale 1ns/1ps
module bld_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic dn_req_valid,
    input wire logic dn_done,
    input wire logic dn_fwd,
    input wire logic up_req_valid,
    input wire logic up_done,
    input wire logic up_fwd,
    input wire logic sec_sys_err_n,
    input wire logic pri_sys_err
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Each request answered one cycle later, nothing unasked
    dn_answer_a: assert property (dn_req_valid |=> dn_done)
        else $error("downstream request not answered");
    dn_quiet_a: assert property (!dn_req_valid |=> !dn_done && !dn_fwd)
        else $error("downstream answer without request");
    up_answer_a: assert property (up_req_valid |=> up_done)
        else $error("upstream request not answered");
    up_quiet_a: assert property (!up_req_valid |=> !up_done && !up_fwd)
        else $error("upstream answer without request");
    // APB ready only after an access cycle, one cycle long
    apb_ready_a: assert property (pready |-> $past(psel && penable) ##1 !pready)
        else $error("ready outside an access");
    apb_err_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Error pulse follows a new secondary assertion, once
    serr_src_a: assert property (pri_sys_err |-> !$past(sec_sys_err_n) && $past(sec_sys_err_n, 2))
        else $error("error pulse without new secondary error");
    serr_once_a: assert property (pri_sys_err |=> !pri_sys_err)
        else $error("error pulse longer than one cycle");
    cover property (dn_done && dn_fwd);
    cover property (up_done && up_fwd);
    cover property (pri_sys_err);
    cover property (pslverr);
endmodule
bind bld_top bld_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
    .dn_req_valid, .dn_done, .dn_fwd, .up_req_valid, .up_done, .up_fwd,
    .sec_sys_err_n, .pri_sys_err);

// [testbench/bld_sec_agent.sv]
/* Secondary bus agent: upstream requests and the system error line.
   Assumes the caller invokes its tasks right after a rising pclk edge. */
`timescale 1ns/1ps
module bld_sec_agent (
    output logic        up_req_valid,
    output logic        up_req_io,
    output logic [31:0] up_req_addr,
    output logic        sec_sys_err_n
);
    // Idle at time zero, error line released
    initial begin
        up_req_valid = 1'b0;
        up_req_io = 1'b0;
        up_req_addr = 32'h0;
        sec_sys_err_n = 1'b1;
    end
    // Present one request
    task automatic start(input logic io, input logic [31:0] a);
        up_req_valid <= 1'b1;
        up_req_io <= io;
        up_req_addr <= a;
    endtask
    // Withdraw; address no longer meaningful, so scramble it
    task automatic stop();
        up_req_valid <= 1'b0;
        up_req_addr <= ~up_req_addr;
    endtask
    task automatic serr(input logic v);
        sec_sys_err_n <= v;
    endtask
endmodule

// [testbench/bld_top_tb.sv]
/* Self-checking bench for bld_top: registers, forwarding, error, irq.
   Assumes the APB timing and one-cycle decode answers of the design. */
`timescale 1ns/1ps
module bld_top_tb;
    import bld_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, dn_req_addr, up_req_addr, rd, r, a;
    logic        dn_req_valid, dn_req_io, dn_done, dn_fwd;
    logic        up_req_valid, up_req_io, up_done, up_fwd, sec_sys_err_n, pri_sys_err, irq;
    logic [31:0] rs = 32'd92891;
    logic [31:0] iob, iol, mb, ml;   // Shadow windows
    logic [15:0] bc, cmd;            // Shadow control and command
    int          n_fail, comparisons;
    logic [31:0] ca [12] = '{32'h0009FFFF, 32'h000A0000, 32'h000BFFFF, 32'h000C0000,
        32'h3AF, 32'h3B0, 32'h3BB, 32'h3BC, 32'h3DF, 32'h3E0, 32'h7C0, 32'h103B0};
    logic [15:0] cb [5] = '{16'h0000, 16'h0008, 16'h0018, 16'h000C, 16'h0004};

    bld_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .dn_req_valid, .dn_req_io, .dn_req_addr, .dn_done, .dn_fwd,
        .up_req_valid, .up_req_io, .up_req_addr, .up_done, .up_fwd, .sec_sys_err_n,
        .pri_sys_err, .irq);
    bld_sec_agent u_sec (.up_req_valid, .up_req_io, .up_req_addr, .sec_sys_err_n);

    ////////////////////////////////////////////////////////////////
    // Expectation functions
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    function automatic logic leg(input logic io, input logic [31:0] x);
        if (!bc[3]) return 1'b0;
        if (!io) return x >= 32'h000A0000 && x <= 32'h000BFFFF;
        return x[31:16] == 16'h0 && (!bc[4] || x[15:10] == 6'h0) &&
            ((x[9:0] >= 10'h3B0 && x[9:0] <= 10'h3BB) || (x[9:0] >= 10'h3C0 && x[9:0] <= 10'h3DF));
    endfunction
    function automatic logic inwin(input logic io, input logic [31:0] x);
        return io ? (x >= iob && x <= iol) : (x >= mb && x <= ml);
    endfunction
    function automatic logic atop(input logic io, input logic [31:0] x);
        return io && inwin(io, x) && x[31:16] == 16'h0 && x[9:8] != 2'b00;
    endfunction
    function automatic logic exp_dn(input logic io, input logic [31:0] x);
        return (io ? cmd[0] : cmd[1]) && (leg(io, x) || (inwin(io, x) && !(bc[2] && atop(io, x))));
    endfunction
    function automatic logic exp_up(input logic io, input logic [31:0] x);
        return !leg(io, x) && (!inwin(io, x) || (bc[2] && atop(io, x)));
    endfunction

    ////////////////////////////////////////////////////////////////
    // Bus and request tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [15:0] b, input logic [15:0] c);
        apb(1'b1, OFS_BRIDGE_CTRL, {16'h0, b});
        apb(1'b1, OFS_COMMAND, {16'h0, c});
        bc = b;
        cmd = c;
    endtask
    task automatic win(input logic [31:0] b0, input logic [31:0] l0,
                       input logic [31:0] b1, input logic [31:0] l1);
        apb(1'b1, OFS_IO_BASE, b0);
        apb(1'b1, OFS_IO_LIMIT, l0);
        apb(1'b1, OFS_MEM_BASE, b1);
        apb(1'b1, OFS_MEM_LIMIT, l1);
        iob = b0;
        iol = l0;
        mb = b1;
        ml = l1;
    endtask
    // Same address offered downstream and upstream together
    task automatic req(input logic io, input logic [31:0] x);
        @(posedge pclk);
        dn_req_valid <= 1'b1;
        dn_req_io <= io;
        dn_req_addr <= x;
        u_sec.start(io, x);
        @(posedge pclk);
        dn_req_valid <= 1'b0;
        dn_req_addr <= ~x;
        u_sec.stop();
        #1;
        check("dn_done", {dn_done, up_done}, 2'b11);
        check("dn_fwd", dn_fwd, exp_dn(io, x));
        check("up_fwd", up_fwd, exp_up(io, x));
    endtask
    // Hold the secondary error low a while, count forwarded pulses
    task automatic serr(input int exp);
        int c = 0;
        @(posedge pclk);
        u_sec.serr(1'b0);
        repeat (6) begin
            @(posedge pclk);
            #1;
            c += (pri_sys_err === 1'b1);
        end
        @(posedge pclk);
        u_sec.serr(1'b1);
        repeat (2) @(posedge pclk);
        check("serr_pulses", c, exp);
    endtask
    task automatic results();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // Clock, watchdog, main sequence
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        results();
    end
    initial begin
        {presetn, psel, penable, pwrite, dn_req_valid, dn_req_io} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        dn_req_addr = 32'h0;
        {bc, cmd, iol, ml} = '0;
        {iob, mb} = {2{32'hFFFFFFFF}};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset_value", rd, (i == 2 || i == 4) ? 32'hFFFFFFFF : 32'h0);
        end
        apb(1'b1, 8'h24, 32'hFFFFFFFF);
        apb(1'b0, 8'h24, 32'h0);
        check("unmapped", {err, rd}, {1'b1, 32'h0});
        apb(1'b1, OFS_BRIDGE_CTRL, 32'hFFFFFFFF);
        apb(1'b0, OFS_BRIDGE_CTRL, 32'h0);
        check("bridge_control", rd, 32'h0000001E);
        cfg(16'h0000, 16'h0003);
        win(32'h0, 32'h00000FFF, 32'h000B0000, 32'h000CFFFF);
        for (int j = 0; j < 5; j++) begin
            cfg(cb[j], 16'h0003);
            foreach (ca[i]) begin
                req(1'b1, ca[i]);
                req(1'b0, ca[i]);
            end
        end
        for (int n = 0; n < 400; n++) begin
            if (n % 40 == 0) begin
                r = rnd();
                win(r & 32'hFFFF, (r & 32'hFFFF) + (rnd() & 32'h3FFF),
                    32'h00080000 + (r >> 14), 32'h000C0000 + (rnd() & 32'h3FFFF));
            end
            if (n % 10 == 0) cfg(16'(rnd() & 32'h1E), 16'(rnd() & 32'h103));
            r = rnd();
            case (r[1:0])
                2'd0: a = 32'h000A0000 + (r >> 15);
                2'd1: a = {15'h0, r[16], r[15:10], 10'h3B0 + 10'(r[25:20])};
                2'd2: a = iob + (r >> 20);
                default: a = rnd();
            endcase
            req(r[31], a);
        end
        // Interrupt: error event raised, masked in, cleared
        apb(1'b1, OFS_INT_STATUS, 32'h7);
        apb(1'b1, OFS_INT_MASK, 32'h7);
        cfg(16'h0002, 16'h0100);
        serr(1);
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        check("status_err", {irq, rd}, {1'b1, 32'h1});
        apb(1'b1, OFS_INT_STATUS, 32'h1);
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        check("status_clr", {irq, rd}, {1'b0, 32'h0});
        cfg(16'h0000, 16'h0100);
        serr(0);
        cfg(16'h0002, 16'h0000);
        serr(0);
        // Block and refusal events with the mask closed, then opened for the block event
        apb(1'b1, OFS_INT_MASK, 32'h0);
        win(32'h0, 32'h00000FFF, 32'hFFFFFFFF, 32'h0);
        cfg(16'h000C, 16'h0003);
        req(1'b1, 32'h00000100);
        req(1'b0, 32'h000A0000);
        apb(1'b0, OFS_INT_STATUS, 32'h0);
        check("status_masked", {irq, rd}, {1'b0, 32'h6});
        apb(1'b1, OFS_INT_MASK, 32'h2);
        #11;
        check("irq_unmasked", irq, 1'b1);
        apb(1'b1, OFS_INT_STATUS, 32'h6);
        #11;
        check("irq_cleared", irq, 1'b0);
        results();
    end
endmodule
